// File: logic/fprps_pkg.sv
// Constants, types and timing for the fuse PROM programming controller
// Operation
// - One link per cycle; select high first
// - Raise select to gate level to fuse
// - After pulse: drop supply, enable, sense output
// - First pulse lasts 50 to 100 us
// - Retry pulses between 5 and 15 ms
// - Stop device after 400 ms on one link
// - Repeat link by link until all ones set
// - Limit device pulse time to 5 s
// - Over budget: remove all power 5 s
// - Finally read all words sequentially and compare
// - Edge spacings above 100 ns, at most 1 us
// - Programmer picks verify interval, reads output
package fprps_pkg;

    ////////////////////////////////////////////////////////////////////
    // Array geometry
    localparam int ADDR_W = 12;                  // Word select lines
    localparam int DATA_W = 8;                   // Stored bits per word
    localparam int BIT_W = 3;                    // Bit index width
    localparam logic [ADDR_W-1:0] ADDR_LAST = 12'hfff; // Last word
    localparam logic [ADDR_W-1:0] ADDR_FIRST = 12'h000; // First word

    ////////////////////////////////////////////////////////////////////
    // Times as printed, and derived cycle counts
    localparam int CLK_KHZ = 20000;              // System clock rate
    localparam int EDGE_MIN_NS = 100;            // Edge spacing, exceeded
    localparam int EDGE_MAX_NS = 1000;           // Edge spacing ceiling
    localparam int FIRST_MIN_US = 50;            // First pulse, least
    localparam int FIRST_MAX_US = 100;           // First pulse, most
    localparam int RETRY_MIN_MS = 5;             // Retry pulse, least
    localparam int RETRY_MAX_MS = 15;            // Retry pulse, most
    localparam int LINK_LIMIT_MS = 400;          // Time budget per link
    localparam int HEAT_LIMIT_MS = 5000;         // Device heating budget
    localparam int COOL_MS = 5000;               // Power-off cool down
    localparam int VERIFY_NS = 1000;             // Chosen verify interval

    localparam int EDGE_CYC_I = EDGE_MIN_NS * CLK_KHZ / 1000000 + 1;
    localparam int FIRST_CYC_I = (FIRST_MIN_US * CLK_KHZ + 999) / 1000;
    localparam int VERIFY_CYC_I = VERIFY_NS * CLK_KHZ / 1000000;

    localparam logic [31:0] EDGE_CYC = 32'(EDGE_CYC_I);
    localparam logic [31:0] FIRST_CYC = 32'(FIRST_CYC_I);
    localparam logic [31:0] VERIFY_CYC = 32'(VERIFY_CYC_I);
    localparam logic [31:0] RETRY_CYC_DEF = 32'(RETRY_MIN_MS * CLK_KHZ);
    localparam logic [31:0] LINK_CYC_DEF = 32'(LINK_LIMIT_MS * CLK_KHZ);
    localparam logic [31:0] HEAT_CYC_DEF = 32'(HEAT_LIMIT_MS * CLK_KHZ);
    localparam logic [31:0] COOL_CYC_DEF = 32'(COOL_MS * CLK_KHZ);
    localparam logic [31:0] ONE_32 = 32'h0000_0001;
    localparam logic [31:0] ZERO_32 = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_READ,
        ST_DESEL,
        ST_VOP_ON,
        ST_PULSE,
        ST_GATE_OFF,
        ST_VOP_OFF,
        ST_COOL,
        ST_DONE,
        ST_FAIL
    } fprps_state_e;

    // Outcome codes
    typedef enum logic [1:0] {
        RES_NONE,
        RES_EXTRA,      // Unwanted high bit found
        RES_LINK,       // Link would not open in time
        RES_VERIFY      // Final sequential compare failed
    } fprps_res_e;

    ////////////////////////////////////////////////////////////////////
    // Pin drive toward the programming front end
    typedef struct packed {
        logic [ADDR_W-1:0] word_select_lines;     // Address to device
        logic active_low_select_program_gate;     // Logic level, low=select
        logic program_gate_hv;                    // Lift select to gate level
        logic active_high_select;                 // Second select
        logic [DATA_W-1:0] output_programming_level; // Fuse supply per bit
        logic supply_en;                          // Device main supply
    } fprps_pins_s;

    // Status toward the user
    typedef struct packed {
        logic busy;                               // Sequence running
        logic done;                               // All words verified
        logic fail;                               // Stopped on error
        fprps_res_e code;                         // Why it stopped
        logic [ADDR_W-1:0] fail_addr;             // Word at fault
    } fprps_stat_s;

endpackage

// File: logic/fprps_timer.sv
// Down counter that times one waiting interval of the sequencer
`timescale 1ns/1ps
module fprps_timer (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic load_i,
    input wire logic [31:0] len_i,
    output logic expired_o
);
    import fprps_pkg::*;

    // All state of the timer
    typedef struct packed {
        logic [31:0] cnt;   // Cycles still to wait
    } fprps_tmr_s;

    fprps_tmr_s cur_ff;
    fprps_tmr_s nxt_cur;

    // Interval ends when the count has run out
    assign expired_o = (cur_ff.cnt == ZERO_32);

    ////////////////////////////////////////////////////////////////////
    // Load len-1 so an interval lasts len cycles, else count down
    always_comb begin
        nxt_cur = cur_ff;
        if (load_i) begin
            nxt_cur.cnt = len_i - ONE_32;
        end else if (cur_ff.cnt != ZERO_32) begin
            nxt_cur.cnt = cur_ff.cnt - ONE_32;
        end
    end

    // Register with synchronous reset, frozen while clock enable low
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cur_ff <= '0;
        end else if (ce_i) begin
            cur_ff <= nxt_cur;
        end
    end

endmodule

// File: logic/fprps_prog_ctrl.sv
// Programmer that fuses links in the PROM and verifies every word
`timescale 1ns/1ps
module fprps_prog_ctrl #(
    parameter logic [31:0] RETRY_CYC = fprps_pkg::RETRY_CYC_DEF,
    parameter logic [31:0] LINK_CYC = fprps_pkg::LINK_CYC_DEF,
    parameter logic [31:0] HEAT_CYC = fprps_pkg::HEAT_CYC_DEF,
    parameter logic [31:0] COOL_CYC = fprps_pkg::COOL_CYC_DEF
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic [fprps_pkg::DATA_W-1:0] pat_data_i,
    input wire logic [fprps_pkg::DATA_W-1:0] stored_bit_outputs_i,
    output logic [fprps_pkg::ADDR_W-1:0] pat_addr_o,
    output fprps_pkg::fprps_pins_s pins_o,
    output fprps_pkg::fprps_stat_s stat_o
);
    import fprps_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // All state of the controller
    typedef struct packed {
        fprps_state_e st;               // Sequencer state
        logic verify_ph;                // Final compare pass running
        logic [DATA_W-1:0] sync1;       // First synchroniser stage
        logic [DATA_W-1:0] sync2;       // Second synchroniser stage
        logic [BIT_W-1:0] cur_bit;      // Link being fused
        logic cur_valid;                // A link is in progress
        logic first;                    // Next pulse is the first one
        logic [31:0] link_acc;          // Pulse cycles on this link
        logic [31:0] heat_acc;          // Pulse cycles on this device
        logic [ADDR_W-1:0] keep_adr;    // Word resumed after cool down
        fprps_pins_s pins;              // Pin drive
        fprps_stat_s stat;              // User status
    } fprps_ctl_s;

    fprps_ctl_s cur_ff;
    fprps_ctl_s nxt_cur;

    logic tmr_load;                     // Start a new interval
    logic [31:0] tmr_len;               // Its length in cycles
    logic tmr_exp;                      // Interval over
    logic [DATA_W-1:0] need;            // Ones still to be fused
    logic [DATA_W-1:0] extra;           // Ones that should be zero
    logic [BIT_W-1:0] low_bit;          // Lowest bit still needed
    logic [31:0] pulse_len;             // Length of next pulse

    ////////////////////////////////////////////////////////////////////
    // Interval timer
    fprps_timer u_timer (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .load_i(tmr_load),
        .len_i(tmr_len),
        .expired_o(tmr_exp)
    );

    // Registered outputs
    assign pins_o = cur_ff.pins;
    assign stat_o = cur_ff.stat;
    assign pat_addr_o = cur_ff.pins.word_select_lines;

    ////////////////////////////////////////////////////////////////////
    // Compare sensed word with pattern; intact links read low
    always_comb begin
        need = pat_data_i & ~cur_ff.sync2;
        extra = cur_ff.sync2 & ~pat_data_i;
        low_bit = '0;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            if (need[i]) begin
                low_bit = BIT_W'(i);
            end
        end
        // Short first pulse, long retries
        if (cur_ff.first || !cur_ff.cur_valid ||
            low_bit != cur_ff.cur_bit) begin
            pulse_len = FIRST_CYC;
        end else begin
            pulse_len = RETRY_CYC;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        nxt_cur = cur_ff;
        tmr_load = 1'b0;
        tmr_len = EDGE_CYC;
        // Pins sampled through two flops before use
        nxt_cur.sync1 = stored_bit_outputs_i;
        nxt_cur.sync2 = cur_ff.sync1;
        case (cur_ff.st)
            ST_IDLE, ST_DONE, ST_FAIL: begin
                // Parked: supply on, chip deselected
                if (start_i) begin
                    nxt_cur.st = ST_READ;
                    nxt_cur.verify_ph = 1'b0;
                    nxt_cur.cur_valid = 1'b0;
                    nxt_cur.first = 1'b1;
                    nxt_cur.link_acc = ZERO_32;
                    nxt_cur.heat_acc = ZERO_32;
                    nxt_cur.pins.word_select_lines = ADDR_FIRST;
                    nxt_cur.pins.active_low_select_program_gate = 1'b0;
                    nxt_cur.pins.active_high_select = 1'b1;
                    nxt_cur.stat = '0;
                    nxt_cur.stat.busy = 1'b1;
                    tmr_load = 1'b1;
                    tmr_len = VERIFY_CYC;
                end
            end
            ST_READ: begin
                // Chip enabled, sense at end of verify interval
                if (tmr_exp) begin
                    if (cur_ff.verify_ph) begin
                        // Sequential compare of all words
                        if (cur_ff.sync2 != pat_data_i) begin
                            nxt_cur.st = ST_FAIL;
                            nxt_cur.stat.code = RES_VERIFY;
                        end
                    end else if (extra != '0) begin
                        // Unwanted link found open
                        nxt_cur.st = ST_FAIL;
                        nxt_cur.stat.code = RES_EXTRA;
                    end else if (need != '0) begin
                        if (cur_ff.cur_valid && low_bit == cur_ff.cur_bit &&
                            cur_ff.link_acc >= LINK_CYC) begin
                            // Link will not open: stop device
                            nxt_cur.st = ST_FAIL;
                            nxt_cur.stat.code = RES_LINK;
                        end else if (cur_ff.heat_acc + pulse_len
                            > HEAT_CYC) begin
                            // Heating budget spent: cool down
                            nxt_cur.st = ST_COOL;
                            nxt_cur.pins.supply_en = 1'b0;
                            nxt_cur.pins.active_low_select_program_gate = 1'b0;
                            nxt_cur.pins.active_high_select = 1'b0;
                            nxt_cur.keep_adr = cur_ff.pins.word_select_lines;
                            nxt_cur.pins.word_select_lines = '0;
                            tmr_load = 1'b1;
                            tmr_len = COOL_CYC;
                        end else begin
                            // One link at a time, deselect first
                            if (!cur_ff.cur_valid ||
                                low_bit != cur_ff.cur_bit) begin
                                nxt_cur.link_acc = ZERO_32;
                                nxt_cur.first = 1'b1;
                            end
                            nxt_cur.cur_bit = low_bit;
                            nxt_cur.cur_valid = 1'b1;
                            nxt_cur.st = ST_DESEL;
                            nxt_cur.pins.active_low_select_program_gate = 1'b1;
                            tmr_load = 1'b1;
                            tmr_len = EDGE_CYC;
                        end
                    end
                    // Word complete: move on to the next word
                    if ((cur_ff.verify_ph && cur_ff.sync2 == pat_data_i) ||
                        (!cur_ff.verify_ph && extra == '0 && need == '0)) begin
                        nxt_cur.cur_valid = 1'b0;
                        nxt_cur.first = 1'b1;
                        nxt_cur.link_acc = ZERO_32;
                        tmr_load = 1'b1;
                        tmr_len = VERIFY_CYC;
                        if (cur_ff.pins.word_select_lines != ADDR_LAST) begin
                            nxt_cur.pins.word_select_lines =
                                cur_ff.pins.word_select_lines + 1'b1;
                        end else if (!cur_ff.verify_ph) begin
                            nxt_cur.verify_ph = 1'b1;
                            nxt_cur.pins.word_select_lines = ADDR_FIRST;
                        end else begin
                            nxt_cur.st = ST_DONE;
                            nxt_cur.stat.done = 1'b1;
                            tmr_load = 1'b0;
                        end
                    end
                    if (nxt_cur.st == ST_FAIL) begin
                        nxt_cur.stat.fail = 1'b1;
                        nxt_cur.stat.fail_addr = cur_ff.pins.word_select_lines;
                    end
                end
            end
            ST_DESEL: begin
                // Select high settled: apply fuse supply to one output
                if (tmr_exp) begin
                    nxt_cur.st = ST_VOP_ON;
                    nxt_cur.pins.output_programming_level =
                        DATA_W'(1) << cur_ff.cur_bit;
                    tmr_load = 1'b1;
                    tmr_len = EDGE_CYC;
                end
            end
            ST_VOP_ON: begin
                // Raise select to gate level for the pulse
                if (tmr_exp) begin
                    nxt_cur.st = ST_PULSE;
                    nxt_cur.pins.program_gate_hv = 1'b1;
                    tmr_load = 1'b1;
                    tmr_len = cur_ff.first ? FIRST_CYC : RETRY_CYC;
                end
            end
            ST_PULSE: begin
                // Count pulse time per link and device
                nxt_cur.link_acc = cur_ff.link_acc + ONE_32;
                nxt_cur.heat_acc = cur_ff.heat_acc + ONE_32;
                if (tmr_exp) begin
                    nxt_cur.st = ST_GATE_OFF;
                    nxt_cur.pins.program_gate_hv = 1'b0;
                    tmr_load = 1'b1;
                    tmr_len = EDGE_CYC;
                end
            end
            ST_GATE_OFF: begin
                // Remove fuse supply after gate drops
                if (tmr_exp) begin
                    nxt_cur.st = ST_VOP_OFF;
                    nxt_cur.pins.output_programming_level = '0;
                    tmr_load = 1'b1;
                    tmr_len = EDGE_CYC;
                end
            end
            ST_VOP_OFF: begin
                // Enable chip, address unchanged, then sense
                if (tmr_exp) begin
                    nxt_cur.st = ST_READ;
                    nxt_cur.first = 1'b0;
                    nxt_cur.pins.active_low_select_program_gate = 1'b0;
                    tmr_load = 1'b1;
                    tmr_len = VERIFY_CYC;
                end
            end
            ST_COOL: begin
                // All power off for the cool-down time
                if (tmr_exp) begin
                    nxt_cur.st = ST_READ;
                    nxt_cur.heat_acc = ZERO_32;
                    nxt_cur.pins.supply_en = 1'b1;
                    nxt_cur.pins.active_high_select = 1'b1;
                    nxt_cur.pins.word_select_lines = cur_ff.keep_adr;
                    tmr_load = 1'b1;
                    tmr_len = VERIFY_CYC;
                end
            end
            default: begin
                nxt_cur.st = ST_IDLE;
            end
        endcase
        // Parked states release the chip and drop busy
        if (nxt_cur.st == ST_DONE || nxt_cur.st == ST_FAIL) begin
            nxt_cur.stat.busy = 1'b0;
            nxt_cur.pins.active_low_select_program_gate = 1'b1;
            nxt_cur.pins.active_high_select = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register, synchronous reset, frozen while clock enable low
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cur_ff <= '0;
            cur_ff.st <= ST_IDLE;
            cur_ff.first <= 1'b1;
            cur_ff.pins.active_low_select_program_gate <= 1'b1;
            cur_ff.pins.supply_en <= 1'b1;
        end else if (ce_i) begin
            cur_ff <= nxt_cur;
        end
    end

endmodule

// File: test/fprps_prog_ctrl_sva.sv
// Checker on the pin drive of the fuse PROM programmer
`timescale 1ns/1ps
module fprps_prog_ctrl_sva
    import fprps_pkg::*;
#(
    parameter logic [31:0] RETRY_CYC = RETRY_CYC_DEF,
    parameter logic [31:0] HEAT_CYC = HEAT_CYC_DEF,
    parameter logic [31:0] COOL_CYC = COOL_CYC_DEF
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire fprps_pkg::fprps_pins_s pins_o
);
    ////////////////////////////////////////////////////////////////////
    localparam int P_LO = FIRST_MIN_US * CLK_KHZ / 1000; // Shortest first
    localparam int P_HI = FIRST_MAX_US * CLK_KHZ / 1000; // Longest first
    logic vop_on; // Some fuse supply applied
    logic hv; // Gate lifted
    logic als; // Select pin level
    logic [31:0] hi_ff; // Length of the running gate pulse
    logic [31:0] heat_ff; // Gate cycles since power came on
    logic [31:0] off_ff; // Cycles with power removed
    assign vop_on = |pins_o.output_programming_level;
    assign hv = pins_o.program_gate_hv;
    assign als = pins_o.active_low_select_program_gate;
    // Pulse, heat and power-off counters
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            hi_ff <= ZERO_32;
            heat_ff <= ZERO_32;
            off_ff <= ZERO_32;
        end else begin
            hi_ff <= hv ? hi_ff + ONE_32 : ZERO_32;
            heat_ff <= pins_o.supply_en ? heat_ff + 32'(hv) : ZERO_32;
            off_ff <= pins_o.supply_en ? ZERO_32 : off_ff + ONE_32;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////
    AST_ONE_LINK: assert property (
        $onehot0(pins_o.output_programming_level))
        else $error("More than one fuse supply on");
    AST_SUPPLY_DESEL: assert property (vop_on |-> als)
        else $error("Fuse supply while chip selected");
    AST_GATE_SUPPLY: assert property (hv |-> vop_on && als)
        else $error("Gate lifted without fuse supply");
    AST_PULSE_LEN: assert property (
        $fell(hv) |-> (hi_ff >= P_LO && hi_ff <= P_HI) || hi_ff == RETRY_CYC)
        else $error("Gate pulse length out of range");
    AST_LEAD: assert property (
        $rose(hv) |-> $past(vop_on, 3) && !$past(vop_on, 20))
        else $error("Supply to gate spacing wrong");
    AST_TRAIL: assert property (
        $fell(hv) |-> vop_on [*3] ##1 !vop_on)
        else $error("Supply not removed after gate");
    AST_RESELECT: assert property (
        $fell(vop_on) |-> als [*3] ##1 !als)
        else $error("Chip not enabled after supply off");
    AST_ADDR_HOLD: assert property (
        vop_on || hv |-> $stable(pins_o.word_select_lines))
        else $error("Address moved during a pulse");
    AST_HEAT: assert property (heat_ff <= HEAT_CYC)
        else $error("Heating budget exceeded");
    AST_COOL: assert property (
        $rose(pins_o.supply_en) |-> off_ff >= COOL_CYC)
        else $error("Power restored too early");
    AST_POWER_OFF: assert property (
        !pins_o.supply_en |-> !vop_on && !hv && !pins_o.active_high_select)
        else $error("Pins driven while power removed");
endmodule
bind fprps_prog_ctrl fprps_prog_ctrl_sva #(.RETRY_CYC(RETRY_CYC),
    .HEAT_CYC(HEAT_CYC), .COOL_CYC(COOL_CYC))
    chk_u (.sys_clk_i, .sys_rst_i, .pins_o);

// File: test/fprps_prom_model.sv
// Behavioural fuse PROM answering the programmer's pins
`timescale 1ns/1ps
module fprps_prom_model
    import fprps_pkg::*;
(
    input wire logic sys_clk_i,
    input wire fprps_pkg::fprps_pins_s pins_i,
    output logic [fprps_pkg::DATA_W-1:0] stored_bit_outputs_o
);
    logic [DATA_W-1:0] mem [4096]; // Fuse array, 1 = open
    logic [DATA_W-1:0] last; // Last word driven
    logic [ADDR_W-1:0] hard_a; // Word of the strong link
    logic [BIT_W-1:0] hard_b; // Bit of the strong link
    int hard_n; // Cycles it needs, 0 = never
    int acc; // Pulse cycles on the current link
    logic [ADDR_W+BIT_W-1:0] cur; // Current link
    logic [ADDR_W-1:0] a; // Fused word
    logic [BIT_W-1:0] b; // Fused bit
    logic sel; // Chip drives its outputs
    // Blank part, every link intact
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        last = 8'h00;
    end
    assign sel = pins_i.supply_en && !pins_i.active_low_select_program_gate
        && pins_i.active_high_select && !pins_i.program_gate_hv;
    // Deselected outputs float, shown inverted
    assign stored_bit_outputs_o = sel ? mem[pins_i.word_select_lines]
        : ~last;
    // Links open after enough gated current
    always @(posedge sys_clk_i) begin
        if (pins_i.program_gate_hv && pins_i.supply_en
            && $onehot(pins_i.output_programming_level)) begin
            for (int i = 0; i < DATA_W; i++) begin
                if (pins_i.output_programming_level[i]) b = i[BIT_W-1:0];
            end
            a = pins_i.word_select_lines;
            if ({a, b} != cur) acc = 0;
            cur = {a, b};
            acc++;
            if (acc == ((a == hard_a && b == hard_b) ? hard_n : FIRST_CYC_I))
                mem[a][b] <= 1'b1;
        end
        if (sel) last <= mem[pins_i.word_select_lines];
    end
endmodule

// File: test/fprps_prog_ctrl_test.sv
// Self-checking bench for the fuse PROM programmer
`timescale 1ns/1ps
module fprps_prog_ctrl_test;
    import fprps_pkg::*;
    localparam logic [31:0] RETRY = 32'h32; // Shortened retry pulse
    localparam logic [31:0] LINK = 32'h4b0; // Shortened link budget
    localparam logic [31:0] HEAT = 32'h9c4; // Shortened heat budget
    localparam logic [31:0] COOL = 32'h1e; // Shortened cool down
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic start = 1'b0;
    logic [DATA_W-1:0] pat_mem [4096]; // Intended contents
    logic [DATA_W-1:0] rd_data; // Device outputs
    logic [ADDR_W-1:0] pat_addr; // Pattern lookup address
    fprps_pins_s pins;
    fprps_stat_s stat;
    int failures = 0;
    int checks = 0;
    int hn = 0; // Running pulse length
    int on = 0; // Running power-off length
    int plen[$]; // Finished pulse lengths
    int olen[$]; // Finished power-off spans
    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////
    fprps_prog_ctrl #(.RETRY_CYC(RETRY), .LINK_CYC(LINK), .HEAT_CYC(HEAT),
        .COOL_CYC(COOL)) dut_u (.sys_clk_i(clk), .sys_rst_i(rst),
        .ce_i(ce), .start_i(start), .pat_data_i(pat_mem[pat_addr]),
        .stored_bit_outputs_i(rd_data), .pat_addr_o(pat_addr),
        .pins_o(pins), .stat_o(stat));
    fprps_prom_model prom_u (.sys_clk_i(clk), .pins_i(pins),
        .stored_bit_outputs_o(rd_data));
    // Measure gate pulses and power-off spans
    always @(posedge clk) begin
        if (pins.program_gate_hv) begin
            hn++;
        end else if (hn != 0) begin
            plen.push_back(hn);
            hn = 0;
        end
        if (!pins.supply_en) begin
            on++;
        end else if (on != 0) begin
            olen.push_back(on);
            on = 0;
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Blank device and pattern, then reset
    task automatic setup;
        rst <= 1'b1;
        foreach (pat_mem[i]) pat_mem[i] = 8'h00;
        foreach (prom_u.mem[i]) prom_u.mem[i] = 8'h00;
        prom_u.hard_a = 12'h000;
        prom_u.hard_b = 3'h0;
        prom_u.hard_n = FIRST_CYC_I;
        prom_u.acc = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        plen.delete();
        olen.delete();
    endtask
    task automatic go;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_addr(input logic [ADDR_W-1:0] adr);
        for (int n = 0; n < 9000 && pat_addr !== adr; n++) @(posedge clk);
        cmp(pat_addr, adr);
    endtask
    task automatic wait_stop;
        for (int n = 0; n < 9000 && stat.busy !== 1'b0; n++) @(posedge clk);
        cmp(stat.fail, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        setup();
        cmp(pins.active_low_select_program_gate, 1'b1);
        cmp(pins.output_programming_level, 8'h00);
        cmp(pins.program_gate_hv, 1'b0);
        cmp(stat, 18'h0);
        $display("test reset done");
    endtask
    task automatic t_blank;
        setup();
        go();
        wait_addr(12'h001);
        ce <= 1'b0;
        repeat (40) @(posedge clk);
        cmp(pat_addr, 12'h001);
        ce <= 1'b1;
        wait_addr(12'h003);
        cmp(plen.size(), 0);
        cmp(stat.busy, 1'b1);
        $display("test blank done");
    endtask
    task automatic t_first;
        setup();
        pat_mem[0] = 8'h05;
        go();
        wait_addr(12'h001);
        cmp(prom_u.mem[0], 8'h05);
        cmp(plen.size(), 2);
        cmp(plen[1], FIRST_CYC);
        $display("test first done");
    endtask
    task automatic t_retry;
        setup();
        pat_mem[0] = 8'h08;
        prom_u.hard_b = 3'h3;
        prom_u.hard_n = FIRST_CYC_I + 2 * RETRY;
        go();
        wait_addr(12'h001);
        cmp(prom_u.mem[0], 8'h08);
        cmp(plen.size(), 3);
        cmp(plen[2], RETRY);
        $display("test retry done");
    endtask
    task automatic t_limit;
        setup();
        pat_mem[5] = 8'h01;
        prom_u.hard_a = 12'h005;
        prom_u.hard_n = 0;
        go();
        wait_stop();
        cmp(stat.code, RES_LINK);
        cmp(stat.fail_addr, 12'h005);
        cmp(plen.size(), 1 + (LINK - FIRST_CYC) / RETRY);
        $display("test limit done");
    endtask
    task automatic t_extra;
        setup();
        prom_u.mem[2] = 8'h10;
        go();
        wait_stop();
        cmp(stat.code, RES_EXTRA);
        cmp(stat.fail_addr, 12'h002);
        cmp(plen.size(), 0);
        $display("test extra done");
    endtask
    task automatic t_heat;
        setup();
        pat_mem[1] = 8'h07;
        go();
        wait (!pins.supply_en);
        wait (pins.supply_en);
        @(posedge clk);
        cmp(pat_addr, 12'h001);
        wait_addr(12'h002);
        cmp(prom_u.mem[1], 8'h07);
        cmp(olen.size(), 1);
        cmp(olen[0] >= COOL, 1'b1);
        $display("test heat done");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        give_verdict();
    end
    initial begin
        t_reset();
        t_blank();
        t_first();
        t_retry();
        t_limit();
        t_extra();
        t_heat();
        give_verdict();
    end
endmodule
